// File: inc/serial_audio_pkg.sv
// Constants, register map and carrier types of the synchronous serial audio port
// Overview of operation
// R1: 12-bit divide value, ratio up to 8190
// R2: Divide value zero stops the divider
// R3: Each divided level lasts divide-value periods
// R4: Transmit clock from receiver, divider or pin
// R5: Transmit clock pin continuous or transfer-only
// R6: Software avoids pin source with continuous output
// R7: Receive clock from transmitter, divider or pin
// R8: Receive clock pin continuous or transfer-only
// R9: External pin clocks kept below stated ratios
// R10: Frame: start, sync data, then shifted words
// R11: All-empty flag when holding and shifter idle
// R12: Holding-free flag once holding moves to shifter
// R13: Full shifter copies to holding, sets ready
// R14: Unread holding overwritten, overrun flag set
// R15: Continuous start on write or enable
// R16: Start on other side, edges or levels
// R17: Receiver may start on compare pattern
// R18: Frame pin waveform chosen, period sets repetition
// R19: Frame pulse lasts 1 to 16 bits
// R20: Sync tag sampled or sent during frame sync
// R21: Sync sent only when enabled, data wins
// R22: Receive sync captured through receive shifter; the code samples it from the data pin into a separate sync register
// R23: Sync-detected flag on selected frame edge
package serial_audio_pkg;
	localparam int ADDR_W = 8;
	localparam int DIV_W = 12;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// Byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_RCMR = 8'h10;
	localparam logic [7:0] OFF_RFMR = 8'h14;
	localparam logic [7:0] OFF_TCMR = 8'h18;
	localparam logic [7:0] OFF_TFMR = 8'h1C;
	localparam logic [7:0] OFF_RHR = 8'h20;
	localparam logic [7:0] OFF_THR = 8'h24;
	localparam logic [7:0] OFF_RSHR = 8'h30;
	localparam logic [7:0] OFF_TSHR = 8'h34;
	localparam logic [7:0] OFF_RCMP = 8'h38;
	localparam logic [7:0] OFF_STAT = 8'h40;
	// Control bits
	localparam int CTRL_RX_EN = 0;
	localparam int CTRL_RX_DIS = 1;
	localparam int CTRL_TX_EN = 8;
	localparam int CTRL_TX_DIS = 9;
	// Status bits
	localparam int ST_TX_FREE = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_RX_FULL = 4;
	localparam int ST_RX_OVR = 5;
	localparam int ST_TX_SYNC = 10;
	localparam int ST_RX_SYNC = 11;
	localparam int ST_RX_ON = 16;
	localparam int ST_TX_ON = 17;
	// Synchronised pin indices
	localparam int PIN_RK = 0;
	localparam int PIN_TK = 1;
	localparam int PIN_RF = 2;
	localparam int PIN_TF = 3;
	localparam int PIN_RD = 4;
	localparam int PIN_N = 5;
	// Clock source and clock output codes
	localparam logic [1:0] SRC_DIV = 2'h0;
	localparam logic [1:0] SRC_OTHER = 2'h1;
	localparam logic [1:0] SRC_PIN = 2'h2;
	localparam logic [2:0] CKO_CONT = 3'h1;
	localparam logic [2:0] CKO_XFER = 3'h2;
	// Start event codes
	localparam logic [3:0] START_CONT = 4'h0;
	localparam logic [3:0] START_OTHER = 4'h1;
	localparam logic [3:0] START_LOW = 4'h2;
	localparam logic [3:0] START_HIGH = 4'h3;
	localparam logic [3:0] START_FALL = 4'h4;
	localparam logic [3:0] START_RISE = 4'h5;
	localparam logic [3:0] START_LEVEL = 4'h6;
	localparam logic [3:0] START_EDGE = 4'h7;
	localparam logic [3:0] START_CMP = 4'h8;
	// Frame sync waveform codes
	localparam logic [2:0] FSO_INPUT = 3'h0;
	localparam logic [2:0] FSO_NEG = 3'h1;
	localparam logic [2:0] FSO_POS = 3'h2;
	localparam logic [2:0] FSO_LOW = 3'h3;
	localparam logic [2:0] FSO_HIGH = 3'h4;
	localparam logic [2:0] FSO_TOGGLE = 3'h5;
	// Clock mode word, one per side
	typedef struct packed {
		logic [7:0] period;
		logic [7:0] start_delay;
		logic [3:0] pad1;
		logic [3:0] start_select;
		logic [1:0] pad0;
		logic clock_invert;
		logic [2:0] clock_output_mode;
		logic [1:0] clock_source_select;
	} clk_mode_t;
	// Frame mode word, one per side
	typedef struct packed {
		logic [6:0] pad1;
		logic frame_edge_select;
		logic sync_data_enable;
		logic [2:0] frame_sync_output_select;
		logic [3:0] frame_sync_length;
		logic [3:0] words_per_frame;
		logic [4:0] pad0;
		logic data_default;
		logic msb_first;
		logic [4:0] data_length;
	} frame_mode_t;
	// Level and edge pulses of a clock or pin
	typedef struct packed {
		logic lvl;
		logic rise;
		logic fall;
	} clk_edge_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_LEAD = 4'b0100,
		ST_DATA = 4'b1000
	} side_state_t;
endpackage

// File: src/sync_serial_audio_port.sv
// Serial side engine and top level of the synchronous serial audio port
`timescale 1ns/1ps
module serial_side_engine #(
	parameter bit IS_RX = 1'b0
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic en_in,
	input wire logic tick_in,
	input wire serial_audio_pkg::clk_mode_t cmode_in,
	input wire serial_audio_pkg::frame_mode_t fmode_in,
	input wire serial_audio_pkg::clk_edge_t frame_in,
	input wire logic other_start_in,
	input wire logic data_in,
	input wire logic [31:0] word_in,
	input wire logic word_valid_in,
	input wire logic [15:0] aux_in,
	output logic start_out,
	output logic busy_out,
	output logic frame_out,
	output logic frame_oe_out,
	output logic data_out,
	output logic load_out,
	output logic word_done_out,
	output logic [31:0] word_out,
	output logic sync_done_out,
	output logic [15:0] sync_word_out
);
	import serial_audio_pkg::*;
	side_state_t state_q, state_d;
	logic [7:0] lead_q; // Lead bit shown now
	logic [4:0] idx_q; // Data bit shown now
	logic [3:0] wcnt_q; // Word within frame
	logic [4:0] fcnt_q; // Frame bits, saturates
	logic [8:0] per_q; // Period counter
	logic [15:0] cmp_q; // Last received bits
	logic [15:0] sync_q; // Captured sync tag
	logic [31:0] shift_q; // Shifter
	logic armed_q, tog_q, start_req, fs_w, tx_bit;
	logic [31:0] rx_next;
	wire [4:0] fsbits = {1'b0, fmode_in.frame_sync_length} + 5'h01;
	wire cont = cmode_in.start_select == START_CONT;
	// R21: sent sync tag only when enabled and start not continuous; receive tag always
	wire sync_on = IS_RX || (fmode_in.sync_data_enable && !cont);
	wire drive_fs = fmode_in.frame_sync_output_select != FSO_INPUT;
	// R18: period counter paces driven frames
	wire per_mode = drive_fs && (cmode_in.period != 8'h00);
	wire per_hit = tick_in && (per_q == {cmode_in.period, 1'b1});
	// R17: match over last sync-length bits
	wire [15:0] cmp_mask = 16'hFFFF >> (5'h10 - fsbits);
	wire cmp_hit = ((cmp_q ^ aux_in) & cmp_mask) == 16'h0000;
	wire start_hit = (state_q == ST_WAIT) && tick_in && (start_req || armed_q);
	wire no_lead = cmode_in.start_delay == 8'h00;
	wire lead_end = (state_q == ST_LEAD) && tick_in && ({1'b0, lead_q} + 9'h001 == {1'b0, cmode_in.start_delay});
	wire word_end = (state_q == ST_DATA) && tick_in && (idx_q == fmode_in.data_length);
	wire last_word = wcnt_q == fmode_in.words_per_frame;
	wire begin_word = (start_hit && no_lead) || lead_end || (word_end && !last_word);
	wire [4:0] bit_pos = fmode_in.msb_first ? (fmode_in.data_length - idx_q) : idx_q;
	wire sync_bit = sync_on && (lead_q < {3'h0, fsbits});
	wire busy = (state_q == ST_LEAD) || (state_q == ST_DATA);
	// R19: pulse covers first sync-length bits
	wire pulse = busy && (fcnt_q < fsbits);
	assign start_out = start_hit;
	assign busy_out = busy;
	assign load_out = !IS_RX && begin_word && word_valid_in;
	// R13: finished word handed to holding
	assign word_done_out = IS_RX && word_end;
	assign word_out = rx_next;
	// R22: sync tag closed when data begins
	assign sync_done_out = IS_RX && lead_end;
	assign sync_word_out = sync_q;

	// Start event selection
	always_comb
	begin
		start_req = 1'b0;
		if (per_mode)
			start_req = per_hit;
		else
			case (cmode_in.start_select)
				// R15: continuous start
				START_CONT: start_req = IS_RX ? en_in : word_valid_in;
				// R16: frame pin and other-side starts
				START_OTHER: start_req = other_start_in;
				START_LOW: start_req = !frame_in.lvl;
				START_HIGH: start_req = frame_in.lvl;
				START_FALL: start_req = frame_in.fall;
				START_RISE: start_req = frame_in.rise;
				START_LEVEL: start_req = frame_in.rise || frame_in.fall;
				START_EDGE: start_req = frame_in.rise || frame_in.fall;
				// R17: compare start, receiver only
				START_CMP: start_req = IS_RX && cmp_hit;
				default: start_req = 1'b0;
			endcase
	end

	// Received word with the current bit merged
	always_comb
	begin
		rx_next = shift_q;
		rx_next[bit_pos] = data_in;
	end

	// Serial output bit: data, sync tag or idle level
	always_comb
	begin
		tx_bit = fmode_in.data_default;
		if (state_q == ST_DATA)
			tx_bit = shift_q[bit_pos];
		// R20: sync tag during frame sync
		else if ((state_q == ST_LEAD) && sync_bit)
			tx_bit = aux_in[lead_q[3:0]];
	end

	// R18: frame pin waveform
	always_comb
	begin
		case (fmode_in.frame_sync_output_select)
			FSO_NEG: fs_w = !pulse;
			FSO_POS: fs_w = pulse;
			FSO_LOW: fs_w = state_q != ST_DATA;
			FSO_HIGH: fs_w = state_q == ST_DATA;
			FSO_TOGGLE: fs_w = tog_q;
			default: fs_w = 1'b0;
		endcase
	end

	// R10: idle, wait for start, lead, data
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (en_in) state_d = ST_WAIT;
			ST_WAIT:
				if (!en_in)
					state_d = ST_IDLE;
				else if (start_hit)
					state_d = no_lead ? ST_DATA : ST_LEAD;
			ST_LEAD:
				if (!en_in)
					state_d = ST_IDLE;
				// R21: data takes over at start delay
				else if (lead_end)
					state_d = ST_DATA;
			ST_DATA:
				if (!en_in)
					state_d = ST_IDLE;
				else if (word_end && last_word)
					state_d = ST_WAIT;
			default: state_d = ST_IDLE;
		endcase
	end

	// Sequencing counters and start latch
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			state_q <= ST_IDLE;
			armed_q <= 1'b0;
			tog_q <= 1'b0;
			per_q <= 9'h000;
			lead_q <= 8'h00;
			fcnt_q <= 5'h00;
			wcnt_q <= 4'h0;
			idx_q <= 5'h00;
		end
		else
		begin
			state_q <= state_d;
			// Events between ticks are held until the next tick
			armed_q <= (state_q == ST_WAIT) && !start_hit && (armed_q || start_req);
			tog_q <= tog_q ^ start_hit;
			per_q <= (!per_mode || per_hit) ? 9'h000 : per_q + {8'h00, tick_in};
			if (start_hit)
				lead_q <= 8'h00;
			else if ((state_q == ST_LEAD) && tick_in)
				lead_q <= lead_q + 8'h01;
			if (start_hit)
				fcnt_q <= 5'h00;
			else if (busy && tick_in && (fcnt_q != 5'h10))
				fcnt_q <= fcnt_q + 5'h01;
			if (start_hit)
				wcnt_q <= 4'h0;
			else if (word_end)
				wcnt_q <= wcnt_q + 4'h1;
			if (begin_word)
				idx_q <= 5'h00;
			else if ((state_q == ST_DATA) && tick_in)
				idx_q <= idx_q + 5'h01;
		end
	end

	// Shifter, sync capture and registered pins
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			shift_q <= REG_RST;
			cmp_q <= 16'h0000;
			sync_q <= 16'h0000;
			data_out <= 1'b0;
			frame_out <= 1'b0;
			frame_oe_out <= 1'b0;
		end
		else
		begin
			cmp_q <= tick_in ? {cmp_q[14:0], data_in} : cmp_q;
			if (IS_RX)
				shift_q <= begin_word ? REG_RST : (((state_q == ST_DATA) && tick_in) ? rx_next : shift_q);
			// R10: holding word loaded into shifter
			else if (begin_word)
				shift_q <= word_in;
			// R20: receive tag sampled during lead
			if (IS_RX && (state_q == ST_LEAD) && tick_in && sync_bit)
				sync_q[lead_q[3:0]] <= data_in;
			data_out <= !IS_RX && tx_bit;
			frame_out <= fs_w;
			frame_oe_out <= drive_fs;
		end
	end
endmodule

module sync_serial_audio_port #(
	parameter int DIV_WIDTH = serial_audio_pkg::DIV_W
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [serial_audio_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic rx_clock_pin_in,
	output logic rx_clock_pin_out,
	output logic rx_clock_pin_oe_out,
	input wire logic tx_clock_pin_in,
	output logic tx_clock_pin_out,
	output logic tx_clock_pin_oe_out,
	input wire logic rx_frame_pin_in,
	output logic rx_frame_pin_out,
	output logic rx_frame_pin_oe_out,
	input wire logic tx_frame_pin_in,
	output logic tx_frame_pin_out,
	output logic tx_frame_pin_oe_out,
	input wire logic rx_data_pin_in,
	output logic tx_data_pin_out
);
	import serial_audio_pkg::*;
	localparam logic [DIV_WIDTH-1:0] DIV_ONE = 1;
	clk_mode_t tcmode_q, rcmode_q;
	frame_mode_t tfmode_q, rfmode_q;
	logic [DIV_WIDTH-1:0] div_q, div_cnt_q;
	logic div_lvl_q;
	logic [31:0] thr_q, rhr_q, stat_w, rd_mux;
	logic [15:0] rshr_q, tshr_q, rcmp_q;
	logic thr_valid_q, rx_full_q, rx_ovr_q, tx_sync_q, rx_sync_q, rx_en_q, tx_en_q;
	logic tx_start, rx_start, tx_busy, rx_busy, tx_load, rx_done, rx_sync_done;
	logic [31:0] rx_word;
	logic [15:0] rx_sync_word;
	clk_edge_t pin_e [PIN_N];
	clk_edge_t div_e, rx_base, tx_base, rx_clk, tx_clk;
	wire [PIN_N-1:0] pin_raw = {rx_data_pin_in, tx_frame_pin_in, rx_frame_pin_in, tx_clock_pin_in, rx_clock_pin_in};

	// Pins: three stages, a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < PIN_N; g++)
		begin : g_pin
			logic [2:0] sy_q;
			logic lvl_q;
			wire agree = sy_q[1] == sy_q[2];
			always_ff @(posedge clk_in)
			begin
				if (srst_in)
				begin
					sy_q <= 3'h0;
					lvl_q <= 1'b0;
				end
				else
				begin
					sy_q <= {sy_q[1:0], pin_raw[g]};
					lvl_q <= agree ? sy_q[1] : lvl_q;
				end
			end
			assign pin_e[g] = {lvl_q, agree && sy_q[1] && !lvl_q, agree && !sy_q[1] && lvl_q};
		end
	endgenerate

	// R2: zero divide value holds divider idle
	wire div_on = div_q != '0;
	// R3: level flips after divide-value cycles
	wire div_flip = div_on && (div_cnt_q == div_q);
	assign div_e = {div_lvl_q, div_flip && !div_lvl_q, div_flip && div_lvl_q};

	// R1: divide counter, ratio twice the value
	always_ff @(posedge clk_in)
	begin
		if (srst_in || !div_on)
		begin
			div_cnt_q <= DIV_ONE;
			div_lvl_q <= 1'b0;
		end
		else
		begin
			div_cnt_q <= div_flip ? DIV_ONE : div_cnt_q + DIV_ONE;
			div_lvl_q <= div_lvl_q ^ div_flip;
		end
	end

	// R4: transmit clock source
	assign tx_base = (tcmode_q.clock_source_select == SRC_PIN) ? pin_e[PIN_TK] : div_e;
	assign tx_clk = (tcmode_q.clock_source_select == SRC_OTHER) ? rx_base : tx_base;
	// R7: receive clock source
	assign rx_base = (rcmode_q.clock_source_select == SRC_PIN) ? pin_e[PIN_RK] : div_e;
	assign rx_clk = (rcmode_q.clock_source_select == SRC_OTHER) ? tx_base : rx_base;
	// Inversion only moves the shifting edge
	wire tx_tick = tcmode_q.clock_invert ? tx_clk.rise : tx_clk.fall;
	wire rx_tick = rcmode_q.clock_invert ? rx_clk.fall : rx_clk.rise;

	// Register decode
	wire wr_ctrl = reg_wr_in && (reg_addr_in == OFF_CTRL);
	wire wr_thr = reg_wr_in && (reg_addr_in == OFF_THR);
	wire rd_rhr = reg_rd_in && (reg_addr_in == OFF_RHR);
	wire rd_stat = reg_rd_in && (reg_addr_in == OFF_STAT);
	// R23: sync flags on chosen frame edge
	wire tx_sync_evt = tfmode_q.frame_edge_select ? pin_e[PIN_TF].fall : pin_e[PIN_TF].rise;
	wire rx_sync_evt = rfmode_q.frame_edge_select ? pin_e[PIN_RF].fall : pin_e[PIN_RF].rise;

	// Status word
	always_comb
	begin
		stat_w = REG_RST;
		// R12: holding free once moved out
		stat_w[ST_TX_FREE] = !thr_valid_q;
		// R11: nothing pending anywhere
		stat_w[ST_TX_EMPTY] = !thr_valid_q && !tx_busy;
		stat_w[ST_RX_FULL] = rx_full_q;
		stat_w[ST_RX_OVR] = rx_ovr_q;
		stat_w[ST_TX_SYNC] = tx_sync_q;
		stat_w[ST_RX_SYNC] = rx_sync_q;
		stat_w[ST_RX_ON] = rx_en_q;
		stat_w[ST_TX_ON] = tx_en_q;
	end

	// Read selection, unmapped reads zero
	always_comb
	begin
		case (reg_addr_in)
			OFF_DIV: rd_mux = {{(32 - DIV_WIDTH){1'b0}}, div_q};
			OFF_RCMR: rd_mux = rcmode_q;
			OFF_RFMR: rd_mux = rfmode_q;
			OFF_TCMR: rd_mux = tcmode_q;
			OFF_TFMR: rd_mux = tfmode_q;
			OFF_RHR: rd_mux = rhr_q;
			OFF_RSHR: rd_mux = {16'h0000, rshr_q};
			OFF_TSHR: rd_mux = {16'h0000, tshr_q};
			OFF_RCMP: rd_mux = {16'h0000, rcmp_q};
			OFF_STAT: rd_mux = stat_w;
			default: rd_mux = REG_RST;
		endcase
	end

	// Configuration registers and read data
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			div_q <= '0;
			rcmode_q <= REG_RST;
			rfmode_q <= REG_RST;
			tcmode_q <= REG_RST;
			tfmode_q <= REG_RST;
			tshr_q <= 16'h0000;
			rcmp_q <= 16'h0000;
			reg_rdata_out <= REG_RST;
		end
		else
		begin
			div_q <= (reg_wr_in && (reg_addr_in == OFF_DIV)) ? reg_wdata_in[DIV_WIDTH-1:0] : div_q;
			rcmode_q <= (reg_wr_in && (reg_addr_in == OFF_RCMR)) ? reg_wdata_in : rcmode_q;
			rfmode_q <= (reg_wr_in && (reg_addr_in == OFF_RFMR)) ? reg_wdata_in : rfmode_q;
			tcmode_q <= (reg_wr_in && (reg_addr_in == OFF_TCMR)) ? reg_wdata_in : tcmode_q;
			tfmode_q <= (reg_wr_in && (reg_addr_in == OFF_TFMR)) ? reg_wdata_in : tfmode_q;
			tshr_q <= (reg_wr_in && (reg_addr_in == OFF_TSHR)) ? reg_wdata_in[15:0] : tshr_q;
			rcmp_q <= (reg_wr_in && (reg_addr_in == OFF_RCMP)) ? reg_wdata_in[15:0] : rcmp_q;
			reg_rdata_out <= reg_rd_in ? rd_mux : REG_RST;
		end
	end

	// Holding registers and flags; a new event beats a clear
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			thr_q <= REG_RST;
			rhr_q <= REG_RST;
			rshr_q <= 16'h0000;
			{thr_valid_q, rx_full_q, rx_ovr_q, tx_sync_q, rx_sync_q, rx_en_q, tx_en_q} <= 7'h00;
		end
		else
		begin
			// Disable wins over enable in one write
			rx_en_q <= !(wr_ctrl && reg_wdata_in[CTRL_RX_DIS]) && (rx_en_q || (wr_ctrl && reg_wdata_in[CTRL_RX_EN]));
			tx_en_q <= !(wr_ctrl && reg_wdata_in[CTRL_TX_DIS]) && (tx_en_q || (wr_ctrl && reg_wdata_in[CTRL_TX_EN]));
			thr_q <= wr_thr ? reg_wdata_in : thr_q;
			thr_valid_q <= wr_thr || (thr_valid_q && !tx_load);
			// R13: word into holding, ready set
			rhr_q <= rx_done ? rx_word : rhr_q;
			rx_full_q <= rx_done || (rx_full_q && !rd_rhr);
			// R14: unread holding overwritten, overrun
			rx_ovr_q <= (rx_done && rx_full_q && !rd_rhr) || (rx_ovr_q && !rd_stat);
			rshr_q <= rx_sync_done ? rx_sync_word : rshr_q;
			tx_sync_q <= tx_sync_evt || (tx_sync_q && !rd_stat);
			rx_sync_q <= rx_sync_evt || (rx_sync_q && !rd_stat);
		end
	end

	// Clock pins carry the uninverted selected clock
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			{tx_clock_pin_out, tx_clock_pin_oe_out, rx_clock_pin_out, rx_clock_pin_oe_out} <= 4'h0;
		end
		else
		begin
			// R5: transmit pin continuous or during transfer
			tx_clock_pin_out <= tx_clk.lvl;
			tx_clock_pin_oe_out <= (tcmode_q.clock_output_mode == CKO_CONT) ||
				((tcmode_q.clock_output_mode == CKO_XFER) && tx_busy);
			// R8: receive pin continuous or during transfer
			rx_clock_pin_out <= rx_clk.lvl;
			rx_clock_pin_oe_out <= (rcmode_q.clock_output_mode == CKO_CONT) ||
				((rcmode_q.clock_output_mode == CKO_XFER) && rx_busy);
		end
	end

	// Transmitter
	serial_side_engine #(.IS_RX(1'b0)) u_tx (
		.clk_in(clk_in), .srst_in(srst_in), .en_in(tx_en_q), .tick_in(tx_tick),
		.cmode_in(tcmode_q), .fmode_in(tfmode_q), .frame_in(pin_e[PIN_TF]),
		.other_start_in(rx_start), .data_in(1'b0), .word_in(thr_q), .word_valid_in(thr_valid_q),
		.aux_in(tshr_q), .start_out(tx_start), .busy_out(tx_busy), .frame_out(tx_frame_pin_out),
		.frame_oe_out(tx_frame_pin_oe_out), .data_out(tx_data_pin_out), .load_out(tx_load),
		.word_done_out(), .word_out(), .sync_done_out(), .sync_word_out()
	);

	// Receiver
	serial_side_engine #(.IS_RX(1'b1)) u_rx (
		.clk_in(clk_in), .srst_in(srst_in), .en_in(rx_en_q), .tick_in(rx_tick),
		.cmode_in(rcmode_q), .fmode_in(rfmode_q), .frame_in(pin_e[PIN_RF]),
		.other_start_in(tx_start), .data_in(pin_e[PIN_RD].lvl), .word_in(REG_RST), .word_valid_in(1'b0),
		.aux_in(rcmp_q), .start_out(rx_start), .busy_out(rx_busy), .frame_out(rx_frame_pin_out),
		.frame_oe_out(rx_frame_pin_oe_out), .data_out(), .load_out(),
		.word_done_out(rx_done), .word_out(rx_word), .sync_done_out(rx_sync_done), .sync_word_out(rx_sync_word)
	);
endmodule

// File: sim/serial_audio_checker.sv
// Port checker of the serial audio port, bound to its top module
`timescale 1ns/1ps
module serial_audio_checker
	import serial_audio_pkg::*;
#(
	parameter int DIV_WIDTH = DIV_W
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic rx_clock_pin_out,
	input wire logic rx_clock_pin_oe_out,
	input wire logic tx_clock_pin_out,
	input wire logic tx_clock_pin_oe_out,
	input wire logic rx_frame_pin_oe_out,
	input wire logic tx_frame_pin_oe_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	logic [31:0] sh_q [16]; // Shadow of written words, by word offset
	logic [4:0] quiet_q; // Cycles since last write, saturating
	logic [DIV_WIDTH-1:0] run_q; // Length of the current clock level
	logic prev_q; // Clock pin level one cycle back
	wire clk_mode_t tcm = sh_q[6];
	wire clk_mode_t rcm = sh_q[4];
	wire frame_mode_t tfm = sh_q[7];
	wire frame_mode_t rfm = sh_q[5];
	wire logic [DIV_WIDTH-1:0] div = sh_q[1][DIV_WIDTH-1:0];
	wire logic edge_seen = tx_clock_pin_out != prev_q;
	// Shadows follow writes; the age counter hides register-to-pin latency
	always_ff @(posedge clk_in)
	begin
		quiet_q <= (srst_in || reg_wr_in) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1F};
		prev_q <= tx_clock_pin_out;
		run_q <= edge_seen ? DIV_WIDTH'(1) : run_q + DIV_WIDTH'(1);
		if (srst_in)
			for (int i = 0; i < 16; i++)
				sh_q[i] <= 32'h0000_0000;
		else if (reg_wr_in && reg_addr_in < 8'h40)
			sh_q[reg_addr_in[5:2]] <= reg_wdata_in;
	end
	property p_div_level;
		quiet_q == 5'h1F && tcm.clock_source_select == SRC_DIV && div != 0 && edge_seen |-> run_q == div;
	endproperty
	a_div_level: assert property (p_div_level) else $error("divided level length wrong");
	property p_div_zero;
		quiet_q == 5'h1F && tcm.clock_source_select == SRC_DIV && div == 0 |-> $stable(tx_clock_pin_out);
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("divider runs at zero");
	property p_inv_free;
		quiet_q == 5'h1F && tcm.clock_source_select == SRC_DIV && rcm.clock_source_select == SRC_DIV
			|-> tx_clock_pin_out == rx_clock_pin_out;
	endproperty
	a_inv_free: assert property (p_inv_free) else $error("inversion reached clock pin");
	property p_tx_cko;
		quiet_q > 5'h02 && tcm.clock_output_mode == CKO_CONT |-> tx_clock_pin_oe_out;
	endproperty
	a_tx_cko: assert property (p_tx_cko) else $error("tx clock pin not driven");
	property p_rx_cko;
		quiet_q > 5'h02 && rcm.clock_output_mode == 3'h0 |-> !rx_clock_pin_oe_out;
	endproperty
	a_rx_cko: assert property (p_rx_cko) else $error("rx clock pin driven while off");
	property p_tx_fso;
		quiet_q > 5'h02 |-> tx_frame_pin_oe_out == (tfm.frame_sync_output_select != FSO_INPUT);
	endproperty
	a_tx_fso: assert property (p_tx_fso) else $error("tx frame pin drive wrong");
	property p_rx_fso;
		quiet_q > 5'h02 |-> rx_frame_pin_oe_out == (rfm.frame_sync_output_select != FSO_INPUT);
	endproperty
	a_rx_fso: assert property (p_rx_fso) else $error("rx frame pin drive wrong");
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule
bind sync_serial_audio_port serial_audio_checker #(.DIV_WIDTH(DIV_WIDTH)) i_serial_audio_checker (.clk_in,
	.srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_clock_pin_out,
	.rx_clock_pin_oe_out, .tx_clock_pin_out, .tx_clock_pin_oe_out, .rx_frame_pin_oe_out, .tx_frame_pin_oe_out);

// File: sim/codec_model.sv
// Codec at the far side of the serial port
`timescale 1ns/1ps
module codec_model (
	input wire logic clk_in,
	input wire logic sck_in,
	input wire logic sdi_in,
	input wire logic level_in,
	output logic sdo_out,
	output logic [7:0] word_out
);
	logic sck_q; // Serial clock one cycle back
	always_ff @(posedge clk_in)
	begin
		sck_q <= sck_in;
		if (sck_in && !sck_q)
			word_out <= {word_out[6:0], sdi_in};
	end
	// Data back to the port at the commanded level
	assign sdo_out = level_in;
endmodule

// File: sim/testbench.sv
// Self-checking testbench of the serial audio port
`timescale 1ns/1ps
module testbench;
	import serial_audio_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic level = 1'b1; // Level the codec sends back
	logic [31:0] rdata;
	logic [7:0] heard; // Last eight bits the codec took in
	logic rk_o, rk_oe, tk_o, tk_oe, rf_o, rf_oe, tf_o, tf_oe, td, sdo;
	int num_errors = 0;
	int tests_run = 0;
	// Master clock, 40 MHz
	always #12.5 clk_in = ~clk_in;
	// Undriven pins sit low through a pull-down
	sync_serial_audio_port i_sync_serial_audio_port (.clk_in, .srst_in, .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.rx_clock_pin_in(rk_oe & rk_o), .rx_clock_pin_out(rk_o), .rx_clock_pin_oe_out(rk_oe),
		.tx_clock_pin_in(tk_oe & tk_o), .tx_clock_pin_out(tk_o), .tx_clock_pin_oe_out(tk_oe),
		.rx_frame_pin_in(rf_oe & rf_o), .rx_frame_pin_out(rf_o), .rx_frame_pin_oe_out(rf_oe),
		.tx_frame_pin_in(tf_oe & tf_o), .tx_frame_pin_out(tf_o), .tx_frame_pin_oe_out(tf_oe),
		.rx_data_pin_in(sdo), .tx_data_pin_out(td));
	codec_model i_codec_model (.clk_in, .sck_in(tk_oe & tk_o), .sdi_in(td), .level_in(level), .sdo_out(sdo),
		.word_out(heard));
	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	// Counted comparison
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read strobe, then masked compare of the word in the next cycle
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 check(rdata & m, e);
	endtask
	// Poll one status bit under a bound
	task automatic wait_stat(input int b);
		int n;
		for (n = 0; n < 200; n++)
		begin
			rd_chk(OFF_STAT, 32'h0000_0000, 32'h0000_0000);
			if (rdata[b] === 1'b1)
				break;
		end
		check({31'h0, rdata[b]}, 32'h0000_0001);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog at 10000 cycles, far beyond the expected several hundred cycles
	initial
	begin
		#250000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		rd_chk(OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0003);
		rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
		wr_reg(OFF_DIV, 32'h0000_0003);
		// Divider source with continuous output, never the pin source
		wr_reg(OFF_TCMR, 32'h0000_0004);
		wr_reg(OFF_TFMR, 32'h0020_0027);
		wr_reg(OFF_RCMR, 32'h0000_0020);
		wr_reg(OFF_RFMR, 32'h0000_0027);
		rd_chk(OFF_TCMR, 32'hFFFF_FFFF, 32'h0000_0004);
		// Receiver alone, codec sending ones
		wr_reg(OFF_CTRL, 32'h0000_0001);
		wait_stat(ST_RX_FULL);
		rd_chk(OFF_RHR, 32'hFFFF_FFFF, 32'h0000_00FF);
		level <= 1'b0;
		repeat (300) @(posedge clk_in);
		wr_reg(OFF_CTRL, 32'h0000_0002);
		rd_chk(OFF_STAT, 32'h0000_0030, 32'h0000_0030);
		rd_chk(OFF_RHR, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(OFF_STAT, 32'h0000_0030, 32'h0000_0000);
		// Transmitter: word first, then enable
		wr_reg(OFF_THR, 32'h0000_00A5);
		wr_reg(OFF_CTRL, 32'h0000_0100);
		wait_stat(ST_TX_FREE);
		rd_chk(OFF_STAT, 32'h0000_0002, 32'h0000_0000);
		for (int n = 0; n < 300 && heard !== 8'hA5; n++)
			@(posedge clk_in);
		check({24'h0, heard}, 32'h0000_00A5);
		wait_stat(ST_TX_EMPTY);
		wr_reg(OFF_DIV, 32'h0000_0000);
		repeat (60) @(posedge clk_in);
		finish_test();
	end
endmodule
